// ==== bench/gauge_mode_control_regs_tb.sv ====
// self-checking bench for the gauge mode/control register bank
`timescale 1ns/1ps
`default_nettype none
module gauge_mode_control_regs_tb;
   logic                clk_i = 1'b0;
   logic                reset_i = 1'b1;
   logic                det = 1'b0;     // battery-detect pin
   logic                cd_auto = 1'b0; // internal charger-disable request
   gmcr_pkg::gmcr_req_t req;
   gmcr_pkg::gmcr_evt_t evt = '0;
   logic [7:0]          rdata, rd;
   logic                al_o, al_oe, cd_o, pu_o, vo_o, run_o, fcc_o, fvm_o, clr_o, srst_o;
   logic [127:0]        soc_t;
   logic [255:0]        ocv_t;
   wire                 pin = al_oe ? al_o : 1'b1; // open drain, pulled up
   wire  [3:0]          pul = {srst_o, clr_o, fvm_o, fcc_o};
   int                  error_cnt = 0, checks_done = 0, cyc = 0;
   // reference model state
   int                  m_mode, m_drv, m_por, m_br, m_ls, m_lv, m_uv;
   int                  m_soc [16], m_ocv [16];
   logic [7:0]          clr_seq [3];  // flag-clearing control writes

   initial forever #2 clk_i = ~clk_i;
   // hang guard: the sequence needs under a thousand cycles
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         error_cnt++;
         final_report();
      end
   end

   gmcr_regs dut_u (.clk_i(clk_i), .reset_i(reset_i), .clk_en_i(1'b1), .req_i(req),
      .evt_i(evt), .battery_detect_input_i(det), .alarm_pin_io_i(pin), .rdata_o(rdata),
      .alarm_pin_io_o(al_o), .alarm_pin_io_oe_o(al_oe), .charger_disable_out_o(cd_o),
      .batt_detect_pullup_en_o(pu_o), .voltage_only_select_o(vo_o), .gauge_run_o(run_o),
      .force_counter_state_o(fcc_o), .force_voltage_state_o(fvm_o),
      .conv_counter_clear_o(clr_o), .soft_reset_o(srst_o), .soc_table_o(soc_t),
      .ocv_table_o(ocv_t), .charger_disable_auto_i(cd_auto));
   gmcr_host_model host_u (.clk_i(clk_i), .rdata_i(rdata), .req_o(req));

   // =====================================================
   // reference model
   task automatic m_reset();
      m_mode = 'h0B;
      {m_drv, m_por, m_br, m_ls, m_lv, m_uv} = {32'd1, 32'd1, 128'd0};
      foreach (m_soc[i]) m_soc[i] = gmcr_pkg::SOC_DEFAULT[i];
      foreach (m_ocv[i]) m_ocv[i] = gmcr_pkg::OCV_DEFAULT[i];
   endtask
   function automatic logic [7:0] m_ctrl();
      logic lvl;
      lvl = !(m_drv == 0 || (m_mode[3] && evt.alarm_cond));
      return {m_uv[0], m_lv[0], m_ls[0], m_por[0], m_br[0], evt.vsrc_voltage, 1'b0, lvl};
   endfunction

   // =====================================================
   // compare and access helpers
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      host_u.rd_reg(a, rd);
      chk(rd, exp);
   endtask
   // pins pass a two-stage synchroniser, so settle before reading
   task automatic rd_ctrl();
      repeat (4) @(negedge clk_i);
      host_u.rd_reg(gmcr_pkg::ADDR_CTRL, rd);
      chk(rd, m_ctrl());
   endtask
   // a strobe must be high for exactly one cycle
   task automatic pulse(input int k);
      int n;
      n = 0;
      repeat (3) begin
         n += pul[k];
         @(negedge clk_i);
      end
      chk(8'(n), 8'h01);
   endtask
   task automatic wr_mode(input logic [7:0] d);
      host_u.wr_reg(gmcr_pkg::ADDR_MODE, d);
      m_mode = d & 8'h1F;
   endtask
   task automatic wr_ctrl(input logic [7:0] d);
      host_u.wr_reg(gmcr_pkg::ADDR_CTRL, d);
      if (d[4]) m_reset();
      else begin
         m_drv = d[0];
         m_por = 0;
         m_br &= (d[3] | det);
         m_ls &= d[5];
         m_lv &= d[6];
         m_uv &= d[7];
      end
   endtask
   task automatic tables();
      for (int i = 0; i < 16; i++) begin
         rd_chk(8'(gmcr_pkg::ADDR_SOC_LO + i), 8'(m_soc[i]));
         rd_chk(8'(gmcr_pkg::ADDR_OCV_LO + 2 * i), m_ocv[i][7:0]);
         rd_chk(8'(gmcr_pkg::ADDR_OCV_LO + 2 * i + 1), m_ocv[i][15:8]);
         chk(soc_t[8*i+:8], 8'(m_soc[i]));
         chk(ocv_t[16*i+:8], m_ocv[i][7:0]);
         chk(ocv_t[16*i+8+:8], m_ocv[i][15:8]);
      end
   endtask

   // =====================================================
   // main sequence
   initial begin
      void'($urandom(32'h8fdb));
      m_reset();
      repeat (4) @(negedge clk_i);
      reset_i = 1'b0;
      rd_chk(gmcr_pkg::ADDR_MODE, 8'h0B);
      rd_ctrl();
      tables();
      for (int i = 0; i < 24; i++) begin
         cd_auto = 1'($urandom);
         wr_mode(8'($urandom));
         chk(8'({vo_o, pu_o, cd_o, run_o}),
            8'({m_mode[0], m_mode[1], m_mode[2] | cd_auto, m_mode[4]}));
         rd_chk(gmcr_pkg::ADDR_MODE, 8'(m_mode));
      end
      wr_mode(8'h3B);
      pulse(0);
      wr_mode(8'h5B);
      pulse(1);
      wr_ctrl(8'h03);
      pulse(2);
      rd_ctrl();
      // sticky flags, each cleared on its own
      evt[4:2] = 3'b111;
      @(negedge clk_i);
      evt[4:2] = 3'b000;
      {m_ls, m_lv, m_uv} = {32'd1, 32'd1, 32'd1};
      rd_ctrl();
      wr_ctrl(8'hE9);
      rd_ctrl();
      // clear uvlo, then low voltage, then low charge, one flag per write
      for (int j = 0; j < 3; j++) begin
         clr_seq = '{8'h61, 8'h21, 8'h01};
         wr_ctrl(clr_seq[j]);
         rd_ctrl();
      end
      evt.vsrc_voltage = 1'b1;
      rd_ctrl();
      // alarm pin forced, then driven by condition and enable
      wr_ctrl(8'h00);
      rd_ctrl();
      wr_ctrl(8'h01);
      wr_mode(8'h08);
      evt.alarm_cond = 1'b1;
      rd_ctrl();
      wr_mode(8'h00);
      rd_ctrl();
      // battery removal flag clears only with detect low
      det = 1'b1;
      m_br = 1;
      rd_ctrl();
      wr_ctrl(8'h01);
      rd_ctrl();
      det = 1'b0;
      // let the low level cross the two-stage synchroniser before clearing
      repeat (3) @(negedge clk_i);
      wr_ctrl(8'h01);
      rd_ctrl();
      // random table contents, then soft reset restores all
      for (int i = 0; i < 16; i++) begin
         m_soc[i] = $urandom % 256;
         m_ocv[i] = $urandom % 65536;
         host_u.wr_reg(8'(gmcr_pkg::ADDR_SOC_LO + i), 8'(m_soc[i]));
         host_u.wr_reg(8'(gmcr_pkg::ADDR_OCV_LO + 2 * i), m_ocv[i][7:0]);
         host_u.wr_reg(8'(gmcr_pkg::ADDR_OCV_LO + 2 * i + 1), m_ocv[i][15:8]);
      end
      tables();
      host_u.wr_reg(8'h20, 8'hFF);
      rd_chk(8'h20, 8'h00);
      wr_ctrl(8'h10);
      pulse(3);
      rd_chk(gmcr_pkg::ADDR_MODE, 8'h0B);
      rd_ctrl();
      tables();
      final_report();
   end

   task automatic final_report();
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
endmodule // gauge_mode_control_regs_tb
`default_nettype wire

// ==== bench/gmcr_host_model.sv ====
// host-side register master that drives the bank's request strobes
`timescale 1ns/1ps
`default_nettype none
module gmcr_host_model (
   input  wire logic                 clk_i,
   input  wire logic [7:0]           rdata_i,
   output var  gmcr_pkg::gmcr_req_t  req_o
);
   // idle bus shows scrambled address/data so stale values are never trusted
   initial req_o = '{wr: 1'b0, rd: 1'b0, addr: 8'hA5, wdata: 8'h5A};
   // write: launched at a falling edge, held across exactly one rising edge
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_i);
      req_o = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(negedge clk_i);
      req_o = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
   endtask
   // read: data taken one full cycle after the strobe, where it must stand
   task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk_i);
      req_o = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'hC3};
      @(negedge clk_i);
      req_o = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'h3C};
      @(negedge clk_i);
      d = rdata_i;
   endtask
endmodule // gmcr_host_model
`default_nettype wire

// ==== logic/gmcr_pkg.sv ====
// package of register map, field positions and table defaults for the gauge mode/control bank
package gmcr_pkg;
   // ==========================================================
   // register addresses (byte addresses of the serial register space)
   localparam logic [7:0] ADDR_MODE    = 8'h00;
   localparam logic [7:0] ADDR_CTRL    = 8'h01;
   localparam logic [7:0] ADDR_OCV_LO  = 8'h30;  // first voltage point, low byte
   localparam logic [7:0] ADDR_OCV_HI  = 8'h4F;  // last voltage point, high byte
   localparam logic [7:0] ADDR_SOC_LO  = 8'h50;  // first charge point
   localparam logic [7:0] ADDR_SOC_HI  = 8'h5F;  // last charge point
   localparam int         NUM_POINTS   = 16;

   // ==========================================================
   // mode register fields
   localparam int MODE_VOLT_ONLY   = 0;
   localparam int MODE_PULLUP      = 1;
   localparam int MODE_CD_FORCE    = 2;
   localparam int MODE_ALARM_EN    = 3;
   localparam int MODE_RUN         = 4;
   localparam int MODE_FORCE_COUNTER_STATE    = 5;
   localparam int MODE_FORCE_VOLTAGE_STATE    = 6;
   localparam logic [7:0] MODE_RESET = 8'h0B; // voltage-only, pull-up, alarm on

   // ==========================================================
   // control register fields
   localparam int CTRL_ALARM_IO    = 0;
   localparam int CTRL_CONV_CLR    = 1;
   localparam int CTRL_VSRC        = 2;
   localparam int CTRL_BATT_REM    = 3;
   localparam int CTRL_POR         = 4;
   localparam int CTRL_LOW_SOC     = 5;
   localparam int CTRL_LOW_VOLT    = 6;
   localparam int CTRL_UVLO        = 7;

   // ==========================================================
   // default table contents
   localparam logic [7:0] SOC_DEFAULT [NUM_POINTS] = '{
      8'h00, 8'h06, 8'h0C, 8'h14, 8'h1E, 8'h28, 8'h32, 8'h3C,
      8'h50, 8'h64, 8'h78, 8'h82, 8'h8C, 8'hA0, 8'hB4, 8'hC8};
   localparam logic [15:0] OCV_DEFAULT [NUM_POINTS] = '{
      16'h1770, 16'h1926, 16'h19B2, 16'h19FB, 16'h1A3E, 16'h1A6D, 16'h1A9D, 16'h1AB6,
      16'h1AD5, 16'h1B01, 16'h1B70, 16'h1BB1, 16'h1BE8, 16'h1C58, 16'h1CF3, 16'h1DA9};

   // register-port write/read request
   typedef struct packed {
      logic       wr;    // write strobe
      logic       rd;    // read strobe
      logic [7:0] addr;  // register address
      logic [7:0] wdata; // write data
   } gmcr_req_t;

   // gauge-side event pulses and status levels
   typedef struct packed {
      logic low_soc;
      logic low_volt;
      logic uvlo;
      logic vsrc_voltage; // level: reported charge comes from voltage mode
      logic alarm_cond;   // level: alarm conditions active
   } gmcr_evt_t;
endpackage : gmcr_pkg

// ==== logic/gmcr_regs.sv ====
// mode and control/status register bank with charge/voltage lookup table
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - bit0 mode selects mixed or voltage-only gauging
// - bit1 mode connects battery-detect pull-up
// - bit2 mode forces charger-disable output high
// - bit3 mode enables alarm function
// - bit4 low puts gauge into frozen standby
// - bit5 write clears relaxation counter, self-clears
// - bit6 write loads relaxation counter maximum
// - control bit0 read returns alarm pin level
// - control bit0 written zero forces alarm low
// - control bit1 write pulses conversion counter clear
// - control bit2 shows voltage-mode charge source
// - removal flag clears only while detect low
// - power-on flag reads one after power-on
// - control bit4 write controls soft reset
// - low-charge flag sticky until written zero
// - low-voltage flag sticky until written zero
// - undervoltage flag sticky until written zero
// - reset loads sixteen default table points
// - power-on and soft reset restore defaults
// - voltage points stored low byte first
module gmcr_regs (
   input  wire logic              clk_i,
   input  wire logic              reset_i,
   input  wire logic              clk_en_i,
   input  wire gmcr_pkg::gmcr_req_t req_i,
   input  wire gmcr_pkg::gmcr_evt_t evt_i,
   input  wire logic              battery_detect_input_i,
   input  wire logic              alarm_pin_io_i,
   output logic [7:0]             rdata_o,
   output logic                   alarm_pin_io_o,
   output logic                   alarm_pin_io_oe_o,
   output logic                   charger_disable_out_o,
   output logic                   batt_detect_pullup_en_o,
   output logic                   voltage_only_select_o,
   output logic                   gauge_run_o,
   output logic                   force_counter_state_o,
   output logic                   force_voltage_state_o,
   output logic                   conv_counter_clear_o,
   output logic                   soft_reset_o,
   output logic [16*8-1:0]        soc_table_o,
   output logic [16*16-1:0]       ocv_table_o,
   input  wire logic              charger_disable_auto_i
);
   // ==========================================================
   // synchronisers for pins
   logic [1:0] bd_sync;   // battery-detect pin stages
   logic [1:0] alm_sync;  // alarm pin read-back stages
   logic       bd_prev;   // previous synced detect level

   // ==========================================================
   // register state
   logic [6:0] mode;          // bits 6..0 of mode register
   logic       alarm_drive;   // control bit0 write value
   logic       batt_rem;      // sticky removal flag
   logic       por_flag;      // power-on flag
   logic       low_soc;       // sticky low charge
   logic       low_volt;      // sticky low voltage
   logic       uvlo;          // sticky undervoltage lockout
   logic       soft_rst;      // soft reset pulse held one cycle
   logic [7:0]  soc_tab [gmcr_pkg::NUM_POINTS]; // charge points
   logic [15:0] ocv_tab [gmcr_pkg::NUM_POINTS]; // voltage points

   logic wr_mode;
   logic wr_ctrl;
   logic rst_all;  // hard or soft reset
   logic bd_rise;

   assign wr_mode = clk_en_i && req_i.wr && (req_i.addr == gmcr_pkg::ADDR_MODE);
   assign wr_ctrl = clk_en_i && req_i.wr && (req_i.addr == gmcr_pkg::ADDR_CTRL);
   assign rst_all = reset_i || soft_rst;
   assign bd_rise = bd_sync[1] && !bd_prev;

   // ==========================================================
   // pin synchronisers
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         bd_sync  <= 2'h0;
         alm_sync <= 2'h0;
         bd_prev  <= 1'b0;
      end else if (clk_en_i) begin
         bd_sync  <= {bd_sync[0], battery_detect_input_i};
         alm_sync <= {alm_sync[0], alarm_pin_io_i};
         bd_prev  <= bd_sync[1];
      end
   end

   // ==========================================================
   // mode register
   always_ff @(posedge clk_i) begin
      if (rst_all) begin
         mode <= gmcr_pkg::MODE_RESET[6:0];
      end else if (clk_en_i) begin
         mode[gmcr_pkg::MODE_FORCE_COUNTER_STATE] <= 1'b0;
         mode[gmcr_pkg::MODE_FORCE_VOLTAGE_STATE] <= 1'b0;
         if (wr_mode) begin
            mode <= req_i.wdata[6:0];
         end
      end
   end

   // ==========================================================
   // control write bits and soft reset
   always_ff @(posedge clk_i) begin
      if (rst_all) begin
         alarm_drive <= 1'b1;
         soft_rst    <= 1'b0;
      end else if (clk_en_i) begin
         soft_rst <= 1'b0;
         if (wr_ctrl) begin
            alarm_drive <= req_i.wdata[gmcr_pkg::CTRL_ALARM_IO];
            soft_rst    <= req_i.wdata[gmcr_pkg::CTRL_POR];
         end
      end
   end

   // ==========================================================
   // power-on flag: soft reset itself sets it, so not reset by rst_all
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         por_flag <= 1'b1;
      end else if (soft_rst) begin
         por_flag <= 1'b1;
      end else if (clk_en_i && wr_ctrl) begin
         por_flag <= req_i.wdata[gmcr_pkg::CTRL_POR];
      end
   end

   // ==========================================================
   // sticky event flags; a set in the clear cycle wins
   always_ff @(posedge clk_i) begin
      if (rst_all) begin
         batt_rem <= 1'b0;
         low_soc  <= 1'b0;
         low_volt <= 1'b0;
         uvlo     <= 1'b0;
      end else if (clk_en_i) begin
         if (bd_rise) begin
            batt_rem <= 1'b1;
         end else if (wr_ctrl && !req_i.wdata[gmcr_pkg::CTRL_BATT_REM] && !bd_sync[1]) begin
            batt_rem <= 1'b0;
         end
         if (evt_i.low_soc) begin
            low_soc <= 1'b1;
         end else if (wr_ctrl && !req_i.wdata[gmcr_pkg::CTRL_LOW_SOC]) begin
            low_soc <= 1'b0;
         end
         if (evt_i.low_volt) begin
            low_volt <= 1'b1;
         end else if (wr_ctrl && !req_i.wdata[gmcr_pkg::CTRL_LOW_VOLT]) begin
            low_volt <= 1'b0;
         end
         if (evt_i.uvlo) begin
            uvlo <= 1'b1;
         end else if (wr_ctrl && !req_i.wdata[gmcr_pkg::CTRL_UVLO]) begin
            uvlo <= 1'b0;
         end
      end
   end

   // ==========================================================
   // lookup table, one generate entry per point
   genvar gi;
   generate
      for (gi = 0; gi < gmcr_pkg::NUM_POINTS; gi++) begin : g_pt
         localparam logic [7:0] A_LO  = gmcr_pkg::ADDR_OCV_LO + 8'(2*gi);
         localparam logic [7:0] A_HI  = gmcr_pkg::ADDR_OCV_LO + 8'(2*gi+1);
         localparam logic [7:0] A_SOC = gmcr_pkg::ADDR_SOC_LO + 8'(gi);
         always_ff @(posedge clk_i) begin
            if (rst_all) begin
               soc_tab[gi] <= gmcr_pkg::SOC_DEFAULT[gi];
               ocv_tab[gi] <= gmcr_pkg::OCV_DEFAULT[gi];
            end else if (clk_en_i && req_i.wr) begin
               if (req_i.addr == A_LO)  ocv_tab[gi][7:0]  <= req_i.wdata;
               if (req_i.addr == A_HI)  ocv_tab[gi][15:8] <= req_i.wdata;
               if (req_i.addr == A_SOC) soc_tab[gi]       <= req_i.wdata;
            end
         end
         assign soc_table_o[gi*8 +: 8]   = soc_tab[gi];
         assign ocv_table_o[gi*16 +: 16] = ocv_tab[gi];
      end
   endgenerate

   // ==========================================================
   // read data register
   logic [7:0] next_rdata;
   logic [7:0] toff;
   always_comb begin
      next_rdata = 8'h00;
      toff = 8'h00;
      if (req_i.addr == gmcr_pkg::ADDR_MODE) begin
         next_rdata = {1'b0, mode};
      end else if (req_i.addr == gmcr_pkg::ADDR_CTRL) begin
         next_rdata = {uvlo, low_volt, low_soc, por_flag, batt_rem,
                       evt_i.vsrc_voltage, 1'b0, alm_sync[1]};
      end else if (req_i.addr >= gmcr_pkg::ADDR_OCV_LO && req_i.addr <= gmcr_pkg::ADDR_OCV_HI) begin
         toff = req_i.addr - gmcr_pkg::ADDR_OCV_LO;
         next_rdata = toff[0] ? ocv_tab[toff[4:1]][15:8] : ocv_tab[toff[4:1]][7:0];
      end else if (req_i.addr >= gmcr_pkg::ADDR_SOC_LO && req_i.addr <= gmcr_pkg::ADDR_SOC_HI) begin
         toff = req_i.addr - gmcr_pkg::ADDR_SOC_LO;
         next_rdata = soc_tab[toff[3:0]];
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         rdata_o <= 8'h00;
      end else if (clk_en_i && req_i.rd) begin
         rdata_o <= next_rdata;
      end
   end

   // ==========================================================
   // outputs steered by mode and control
   // gauging select
   assign voltage_only_select_o   = mode[gmcr_pkg::MODE_VOLT_ONLY];
   assign batt_detect_pullup_en_o = mode[gmcr_pkg::MODE_PULLUP];
   assign charger_disable_out_o   = mode[gmcr_pkg::MODE_CD_FORCE] | charger_disable_auto_i;
   assign gauge_run_o             = mode[gmcr_pkg::MODE_RUN];
   assign force_counter_state_o   = mode[gmcr_pkg::MODE_FORCE_COUNTER_STATE];
   assign force_voltage_state_o   = mode[gmcr_pkg::MODE_FORCE_VOLTAGE_STATE];
   logic conv_clr;
   always_ff @(posedge clk_i) begin
      if (rst_all) conv_clr <= 1'b0;
      else if (clk_en_i) conv_clr <= wr_ctrl && req_i.wdata[gmcr_pkg::CTRL_CONV_CLR];
   end
   assign conv_counter_clear_o = conv_clr;
   assign soft_reset_o         = soft_rst;
   // open-drain alarm pin low when forced or active
   assign alarm_pin_io_o    = 1'b0;
   assign alarm_pin_io_oe_o = !alarm_drive ||
                              (mode[gmcr_pkg::MODE_ALARM_EN] && evt_i.alarm_cond);

   // ==========================================================
   // checks
   sticky_soc_a: assert property (@(posedge clk_i) disable iff (rst_all)
      low_soc && !(clk_en_i && wr_ctrl) |=> low_soc) else $error("low charge flag dropped");
   sticky_volt_a: assert property (@(posedge clk_i) disable iff (rst_all)
      clk_en_i && evt_i.low_volt |=> low_volt) else $error("low voltage not set");
   sticky_uvlo_a: assert property (@(posedge clk_i) disable iff (rst_all)
      clk_en_i && evt_i.uvlo |=> uvlo) else $error("uvlo not set");
   rem_hold_a: assert property (@(posedge clk_i) disable iff (rst_all)
      batt_rem && bd_sync[1] |=> batt_rem) else $error("removal cleared while high");
   force_clr_a: assert property (@(posedge clk_i) disable iff (rst_all)
      force_counter_state_o && clk_en_i && !wr_mode |=> !force_counter_state_o)
      else $error("force bit stuck");
   alarm_low_a: assert property (@(posedge clk_i) disable iff (reset_i)
      !alarm_drive |-> alarm_pin_io_oe_o) else $error("alarm not forced low");
   bit7_zero_a: assert property (@(posedge clk_i) disable iff (reset_i)
      req_i.addr == gmcr_pkg::ADDR_MODE |-> !next_rdata[7]) else $error("mode bit7 set");
   por_soft_a: assert property (@(posedge clk_i) disable iff (reset_i)
      soft_rst |=> por_flag && mode == gmcr_pkg::MODE_RESET[6:0]) else $error("soft reset");
   cv_soft: cover property (@(posedge clk_i) soft_rst);
   cv_rem: cover property (@(posedge clk_i) bd_rise);
   cv_clr: cover property (@(posedge clk_i) conv_clr);
endmodule : gmcr_regs
`default_nettype wire
